// ---- core/vids_core.sv ----
`timescale 1ns/100ps
// How it works
// - sample code six times per cycle
// - on change, wait half cycle, step
// - difference changed during wait cancels step
// - large gap: step every sample until equal
// - off code at first sample latches off
module vids_core
    import vids_pkg::*;
#(
    parameter int SW_PERIOD_NS = SW_PERIOD_NS_DEF
)
(
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RESET_N,
    // controller conditions
    input  wire logic               REG_ENABLE,
    input  wire logic               BOOT_HOLD_DONE,
    // processor code pins
    input  wire logic [7:0]         VOLTAGE_ID_CODE,
    // reference target
    output logic      [7:0]         REF_CODE,
    output logic      [20:0]        REF_UV,
    output vids_pkg::vids_status_s  STATUS
);

    import vids_pkg::*;

    // clock cycles between samples, rounded down
    localparam int TICK_CYC =
        SW_PERIOD_NS / (SAMPLES_PER_CYCLE * CLK_PERIOD_NS);

    generate
        if (TICK_CYC < 1)
        begin : g_bad_period
            $error("vids_core: switching period too short");
        end
    endgenerate

    // half-cycle wait in ticks must match the sample rate and fit
    // the two-bit wait counter, which cannot hold zero as a count
    generate
        if (int'(WAIT_TICKS) != SAMPLES_PER_CYCLE / 2 || WAIT_TICKS == 2'h0)
        begin : g_bad_wait
            $error("vids_core: wait ticks do not match sampling rate");
        end
    endgenerate

    // disable parks the reference on the boot code, so it must be valid
    generate
        if (vids_classify(CODE_BOOT) != VIDS_CLS_VALID)
        begin : g_bad_boot
            $error("vids_core: boot code is not a valid target");
        end
    endgenerate

    vids_state_e  state_reg;
    vids_state_e  state_next;
    logic [7:0]   ref_reg;
    logic [7:0]   ref_next;
    logic [20:0]  uv_reg;
    logic [20:0]  uv_next;
    logic [8:0]   pend_reg;
    logic [8:0]   pend_next;
    logic [1:0]   wait_reg;
    logic [1:0]   wait_next;
    vids_status_s stat_reg;
    vids_status_s stat_next;

    logic         tick;
    vids_class_e  cls;
    logic [8:0]   diff;
    logic [8:0]   mag;
    logic         big;
    logic [7:0]   stepped;

    vids_tick_gen #(
        .DIV     (TICK_CYC)
    ) u_tick (
        .CLK     (CLK),
        .RESET_N (RESET_N),
        .TICK    (tick)
    );

    // request minus reference, in codes, and one bounded step
    always_comb
    begin
        cls  = vids_classify(VOLTAGE_ID_CODE);
        diff = {1'b0, VOLTAGE_ID_CODE} - {1'b0, ref_reg};
        mag  = diff[8] ? (9'h000 - diff) : diff;
        big  = (mag > 9'h001);
        // one 12.5mV increment, clipped to the gap
        if (diff[8])
            stepped = ref_reg - (big ? STEP_CODES[7:0] : mag[7:0]);
        else
            stepped = ref_reg + (big ? STEP_CODES[7:0] : mag[7:0]);
    end

    // tracking sequencer; acts on sample strobes, except that dropping enable acts on any clock
    always_comb
    begin
        state_next = state_reg;
        ref_next   = ref_reg;
        pend_next  = pend_reg;
        wait_next  = wait_reg;
        stat_next  = stat_reg;
        if (!REG_ENABLE)
        begin
            // dropping enable and reset are the only ways out of latched off
            state_next = VIDS_IDLE;
            ref_next   = CODE_BOOT;
            stat_next  = '0;
        end
        else if (tick)
        begin
            stat_next.invalid = (cls == VIDS_CLS_INVALID);
            case (state_reg)
                VIDS_IDLE:
                begin
                    if (BOOT_HOLD_DONE)
                    begin
                        if (cls == VIDS_CLS_OFF)
                            state_next = VIDS_OFF;
                        else if (cls == VIDS_CLS_VALID)
                        begin
                            ref_next   = VOLTAGE_ID_CODE;
                            state_next = VIDS_TRACK;
                        end
                    end
                end
                VIDS_TRACK:
                begin
                    if (cls == VIDS_CLS_OFF)
                        state_next = VIDS_OFF;
                    else if (cls == VIDS_CLS_VALID && diff != 9'h000)
                    begin
                        pend_next  = diff;
                        wait_next  = WAIT_TICKS;
                        state_next = VIDS_WAIT;
                    end
                end
                VIDS_WAIT:
                begin
                    if (cls == VIDS_CLS_OFF)
                        state_next = VIDS_OFF;
                    else if (cls != VIDS_CLS_VALID || diff != pend_reg)
                        state_next = VIDS_TRACK;
                    else if (wait_reg == 2'h1)
                    begin
                        ref_next   = stepped;
                        state_next = big ? VIDS_SLEW : VIDS_TRACK;
                    end
                    else
                        wait_next = wait_reg - 2'h1;
                end
                VIDS_SLEW:
                begin
                    if (cls == VIDS_CLS_OFF)
                        state_next = VIDS_OFF;
                    else if (cls != VIDS_CLS_VALID || diff == 9'h000)
                        state_next = VIDS_TRACK;
                    else
                        ref_next = stepped;
                end
                VIDS_OFF:
                begin
                    state_next = VIDS_OFF;
                end
                default:
                begin
                    state_next = VIDS_IDLE;
                end
            endcase
        end
        stat_next.shutdown = (state_next == VIDS_OFF);
        stat_next.busy     = (state_next == VIDS_WAIT) ||
                             (state_next == VIDS_SLEW);
        uv_next = vids_code_to_uv(ref_next);
    end

    // register stage; off state keeps the last target for visibility
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            state_reg <= VIDS_IDLE;
            ref_reg   <= CODE_BOOT;
            uv_reg    <= vids_code_to_uv(CODE_BOOT); // boot level
            pend_reg  <= 9'h000;
            wait_reg  <= 2'h0;
            stat_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            ref_reg   <= ref_next;
            uv_reg    <= uv_next;
            pend_reg  <= pend_next;
            wait_reg  <= wait_next;
            stat_reg  <= stat_next;
        end
    end

    assign REF_CODE = ref_reg;
    assign REF_UV   = uv_reg;
    assign STATUS   = stat_reg;

endmodule : vids_core

// ---- core/vids_pkg.sv ----
package vids_pkg;

    // clock and sampling timing
    localparam int          CLK_PERIOD_NS     = 25;
    localparam int          SAMPLES_PER_CYCLE = 6;
    localparam int          SW_PERIOD_NS_DEF  = 1500;
    // half a switching cycle, counted in sample ticks
    localparam logic [1:0]  WAIT_TICKS        = 2'h3;

    // code table landmarks
    localparam logic [7:0]  CODE_LOWEST       = 8'hB2;
    localparam logic [7:0]  CODE_OFF_LOW      = 8'hFE;
    localparam logic [7:0]  CODE_BOOT         = 8'h52;
    // one 12.5 mV increment, counted in 6.25 mV codes
    localparam logic [8:0]  STEP_CODES        = 9'h002;

    // microvolt conversion: target = top - code * step
    localparam logic [20:0] UV_TOP            = 21'h18_9AD4;
    localparam logic [20:0] UV_PER_CODE       = 21'h00_186A;

    typedef enum logic [2:0] {
        VIDS_IDLE  = 3'b000,
        VIDS_TRACK = 3'b001,
        VIDS_WAIT  = 3'b010,
        VIDS_SLEW  = 3'b011,
        VIDS_OFF   = 3'b100
    } vids_state_e;

    typedef enum logic [1:0] {
        VIDS_CLS_VALID   = 2'b00,
        VIDS_CLS_INVALID = 2'b01,
        VIDS_CLS_OFF     = 2'b10
    } vids_class_e;

    typedef struct packed {
        logic shutdown;
        logic invalid;
        logic busy;
    } vids_status_s;

    // sort an incoming code into valid, no-voltage and shutdown
    function automatic vids_class_e vids_classify(input logic [7:0] code);
        if (code >= CODE_OFF_LOW)
            return VIDS_CLS_OFF;
        else if (code > CODE_LOWEST)
            return VIDS_CLS_INVALID;
        else
            return VIDS_CLS_VALID;
    endfunction : vids_classify

    // reference target in microvolts for a valid code
    function automatic logic [20:0] vids_code_to_uv(input logic [7:0] code);
        logic [20:0] prod;
        prod = 21'({13'h0000, code} * UV_PER_CODE);
        return UV_TOP - prod;
    endfunction : vids_code_to_uv

endpackage : vids_pkg

// ---- core/vids_tick_gen.sv ----
`timescale 1ns/100ps
module vids_tick_gen
    import vids_pkg::*;
#(
    parameter int DIV = 10
)
(
    // clock and reset
    input  wire logic CLK,
    input  wire logic RESET_N,
    // one-cycle sample strobe
    output logic      TICK
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    generate
        if (DIV < 1)
        begin : g_bad_div
            $error("vids_tick_gen: DIV must be at least 1");
        end
    endgenerate

    // free-running divider, strobe on wrap
    always_comb
    begin
        if (cnt_reg == CW'(DIV - 1))
            cnt_next = '0;
        else
            cnt_next = cnt_reg + 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    assign TICK = (cnt_reg == CW'(DIV - 1)); // combinational strobe

endmodule : vids_tick_gen

// ---- dv/vids_core_assertions.sv ----
`timescale 1ns/100ps
module vids_core_assertions
    import vids_pkg::*;
#(
    parameter int SW_PERIOD_NS = SW_PERIOD_NS_DEF
)
(
    // clock and reset
    input wire logic                  CLK,
    input wire logic                  RESET_N,
    // controls and code pins
    input wire logic                  REG_ENABLE,
    input wire logic                  BOOT_HOLD_DONE,
    input wire logic [7:0]            VOLTAGE_ID_CODE,
    // reference outputs
    input wire logic [7:0]            REF_CODE,
    input wire logic [20:0]           REF_UV,
    input wire vids_pkg::vids_status_s STATUS
);
    import vids_pkg::*;
    // off code must latch within one tick plus margin
    localparam int OFF_LAT =
        SW_PERIOD_NS / (SAMPLES_PER_CYCLE * CLK_PERIOD_NS) + 2;
    // cycle-exact wait checks only hold when every clock is a sample
    localparam bit ONE_TICK =
        (SW_PERIOD_NS / (SAMPLES_PER_CYCLE * CLK_PERIOD_NS) == 1);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    uv_map_a: assert property (
        REF_UV == UV_TOP - 21'(REF_CODE) * UV_PER_CODE)
        else $error("reference voltage does not match code");
    off_entry_a: assert property (disable iff (!RESET_N || !REG_ENABLE)
        BOOT_HOLD_DONE && VOLTAGE_ID_CODE >= CODE_OFF_LOW
        |-> ##[1:OFF_LAT] STATUS.shutdown)
        else $error("off code did not shut down");
    off_hold_a: assert property (
        STATUS.shutdown && REG_ENABLE |=> STATUS.shutdown)
        else $error("shutdown left while enabled");
    boot_clear_a: assert property (
        !REG_ENABLE |=> REF_CODE == CODE_BOOT && STATUS == '0)
        else $error("disable did not restore boot state");
    step_size_a: assert property (
        $past(REG_ENABLE) && $past(STATUS.busy) && $changed(REF_CODE)
        |-> 8'(REF_CODE - $past(REF_CODE) + 8'h02) <= 8'h04)
        else $error("reference moved more than one increment");
    wait_hold_a: assert property (disable iff (!RESET_N || !REG_ENABLE)
        $rose(STATUS.busy) |=> $stable(REF_CODE)[*2])
        else $error("step taken before half cycle");
    step_due_a: assert property (disable iff (!RESET_N || !REG_ENABLE)
        (ONE_TICK && $rose(STATUS.busy) && $stable(VOLTAGE_ID_CODE))
        ##1 $stable(VOLTAGE_ID_CODE)[*2] |=> $changed(REF_CODE))
        else $error("step missing after steady wait");
    cancel_hold_a: assert property (disable iff (!RESET_N || !REG_ENABLE)
        ONE_TICK && $rose(STATUS.busy) && $changed(VOLTAGE_ID_CODE)
        |=> $stable(REF_CODE)[*3])
        else $error("step taken although the code moved during the wait");
    invalid_keep_a: assert property (
        $past(REG_ENABLE) && STATUS.invalid |-> $stable(REF_CODE))
        else $error("no-voltage code moved the reference");
endmodule : vids_core_assertions

bind vids_core vids_core_assertions #(.SW_PERIOD_NS(SW_PERIOD_NS)) i_chk (
    .CLK             (CLK),
    .RESET_N         (RESET_N),
    .REG_ENABLE      (REG_ENABLE),
    .BOOT_HOLD_DONE  (BOOT_HOLD_DONE),
    .VOLTAGE_ID_CODE (VOLTAGE_ID_CODE),
    .REF_CODE        (REF_CODE),
    .REF_UV          (REF_UV),
    .STATUS          (STATUS)
);

// ---- dv/vids_cpu_model.sv ----
`timescale 1ns/100ps
module vids_cpu_model
(
    // clock
    input  wire logic       clk,
    // target, forced jump and pacing
    input  wire logic [7:0] target,
    input  wire logic       jump,
    input  wire logic [7:0] pace,
    // code pins
    output logic      [7:0] code
);
    logic [7:0] cnt;
    initial code = 8'h52;
    initial cnt = 8'h00;
    // one code per move, jump only when commanded
    // moves spaced by a fixed interval
    always @(negedge clk)
    begin
        cnt <= (cnt >= pace) ? 8'h00 : cnt + 8'h01;
        if (jump)
            code <= target;
        else if (cnt >= pace && code != target)
            code <= (target > code) ? code + 8'h01 : code - 8'h01;
    end
endmodule : vids_cpu_model

// ---- dv/voltage_id_decode_and_stepper_tb.sv ----
`timescale 1ns/100ps
module voltage_id_decode_and_stepper_tb;
    import vids_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, boot = 1'b0, jump = 1'b0;
    logic [7:0] tgt = 8'h52, pace = 8'h0a, cur = 8'h52, last = 8'h52, v;
    logic [7:0] code, ref_code;
    logic [20:0] ref_uv, exp_ref;
    vids_status_s status;
    logic [7:0] exp_q[$];
    int fail_count = 0, checked = 0;

    always #12.5 clk = ~clk;
    vids_cpu_model i_cpu (.clk(clk), .target(tgt), .jump(jump), .pace(pace),
        .code(code));
    vids_core #(.SW_PERIOD_NS(150)) i_dut (.CLK(clk), .RESET_N(rst_n),
        .REG_ENABLE(en), .BOOT_HOLD_DONE(boot), .VOLTAGE_ID_CODE(code),
        .REF_CODE(ref_code), .REF_UV(ref_uv), .STATUS(status));

    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // expected reference path, st codes per step, last step clipped
    task automatic plan(input logic [7:0] to, input logic [7:0] st);
        while (cur != to)
        begin
            if (to > cur)
                cur = (to - cur > st) ? cur + st : to;
            else
                cur = (cur - to > st) ? cur - st : to;
            exp_q.push_back(cur);
        end
    endtask : plan

    // quiet means code at target and nothing pending for 8 cycles
    task automatic settle;
        int n, q;
        q = 0;
        for (n = 0; n < 3000 && q < 8; n++)
        begin
            @(negedge clk);
            q = (status.busy === 1'b0 && code == tgt) ? q + 1 : 0;
        end
        if (q < 8)
        begin
            fail_count++;
            print_verdict();
        end
    endtask : settle

    task automatic go(input logic j, input logic [7:0] to);
        @(negedge clk);
        tgt <= to;
        jump <= j;
        @(negedge clk);
        jump <= 1'b0;
        settle();
    endtask : go

    // every reference move is matched against the oldest note; looked at
    // on the falling edge, half a cycle after the design launched it
    always @(negedge clk)
    begin
        if (ref_code !== last)
        begin
            exp_ref = exp_q.size() > 0 ? 21'(exp_q.pop_front()) : 21'hx;
            check(21'(ref_code), exp_ref);
            check(ref_uv, UV_TOP - exp_ref * UV_PER_CODE);
        end
        last = ref_code;
    end

    initial
    begin
        void'($urandom(32'h5a60));
        repeat (8) @(negedge clk);
        rst_n <= 1'b1;
        check(21'(status), 21'h0);
        go(1'b1, 8'h40);
        boot <= 1'b1;
        plan(8'h40, 8'h40);
        settle();
        plan(8'h45, 8'h01);
        go(1'b0, 8'h45);
        plan(8'h4b, 8'h02);
        go(1'b1, 8'h4b);
        plan(8'h46, 8'h02);
        go(1'b1, 8'h46);
        plan(8'h48, 8'h02);
        @(negedge clk);
        tgt <= 8'h47;
        jump <= 1'b1;
        @(negedge clk);
        tgt <= 8'h48;
        @(negedge clk);
        check(21'(status.busy), 21'h1);
        go(1'b0, 8'h48);
        go(1'b1, 8'hb3);
        check(21'(status.invalid), 21'h1);
        go(1'b1, 8'hfd);
        check(21'(status.invalid), 21'h1);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 3) ? 8'hb2 : 8'($urandom % 179);
            plan(v, 8'h02);
            go(1'b1, v);
        end
        go(1'b1, 8'hfe);
        check(21'(status.shutdown), 21'h1);
        go(1'b1, 8'h40);
        check(21'(status.shutdown), 21'h1);
        en <= 1'b0;
        boot <= 1'b0;
        exp_q.push_back(8'h52);
        go(1'b1, 8'hff);
        check(21'(status), 21'h0);
        en <= 1'b1;
        boot <= 1'b1;
        settle();
        check(21'(status.shutdown), 21'h1);
        check(21'(exp_q.size()), 21'h0);
        print_verdict();
    end
endmodule : voltage_id_decode_and_stepper_tb
